//--- rtl/pic_ctrl.sv
// pin level status, function control and pin 3 compare/capture logic
// assumes the core drives global register moves as one-cycle strobes
// and supplies its free running tick count; pins are asynchronous
//
// Behaviour
// - status register is read-only global slot 25; reserved bits read zero
// - reported levels are true pin levels, ignore polarity, 2..3 cycles late
// - status bits 6..4 show gpio pins 3..1 levels
// - status bits 3..0 show interrupt pins 4..1 levels
// - event flag sets in capture mode, gpio3 an input, when gpio3 level equals its sense
// - match flag sets on low 16-bit compare in tick-irq mode, or in capture mode unless gpio3 is an input with the event flag set
// - both flags clear on control bit 13 written one or watchdog write
// - control register is write-only global slot 26, never read back
// - reset forces every control bit to one
// - control bits 31..28 disable interrupt pins 4..1 when one
// - control bits 27..24 pick high (1) or low (0) active level
// - control bit 23 disables timer interrupt when one
// - bits 21..20 rank timer irq: 11=6, 10=8, 01=10, 00=12
// - gpio direction bit one means input, zero means driven output
// - control bit 17 one leaves dma unlocked, zero locks it out
// - control bit 16 one suppresses extended overflow exception
// - bits 13..12 select pin 3 mode: standard, watchdog, capture, tick-irq
// - watchdog compare uses bits 15..0 of slot 24; upper bits read zero
`timescale 1ns/10ps
`default_nettype none
module pic_ctrl #(
  parameter int TICK_W = 16
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        clk_en,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [4:0]  reg_slot,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  output logic             reg_hit,
  input  wire logic [TICK_W-1:0] free_running_tick_count,
  input  wire logic [3:0]  irq_pin_in,
  input  wire logic [2:0]  gpio_in,
  output logic      [2:0]  gpio_out,
  output logic      [2:0]  gpio_oe,
  output logic      [3:0]  irq_pin_req,
  output logic      [2:0]  gpio_irq_req,
  output logic             tick_irq_off,
  output logic      [3:0]  tick_irq_prio,
  output logic             dma_lockout,
  output logic             extended_overflow_exception_off,
  output logic             watchdog_reset_req
);
  import pic_pkg::*;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [15:0] wdog;
    logic        event_flag;
    logic        match_flag;
    logic        toggle;
    logic        prev_match;
    logic [31:0] rdata;
    logic        hit;
    logic [2:0]  gout;
  } pic_ctrl_state_t;

  pic_ctrl_state_t s_q;
  pic_ctrl_state_t s_d;

  logic [6:0] lvl;
  logic [3:0] irq_lvl;
  logic [2:0] gpio_lvl;

  // pins cross in through two flops before any logic sees them
  pic_sync #(
    .WIDTH(7)
  ) u_sync (
    .clock    (clock),
    .rst      (rst),
    .clk_en   (clk_en),
    .async_in ({gpio_in, irq_pin_in}),
    .sync_out (lvl)
  );

  assign irq_lvl  = lvl[3:0];
  assign gpio_lvl = lvl[6:4];

  function automatic logic [3:0] rank_prio(input logic [1:0] rank);
    case (rank)
      2'b11:   rank_prio = PRIO_RANK3;
      2'b10:   rank_prio = PRIO_RANK2;
      2'b01:   rank_prio = PRIO_RANK1;
      default: rank_prio = PRIO_RANK0;
    endcase
  endfunction : rank_prio

  function automatic logic pin_active(input logic level, input logic high);
    pin_active = (level == high);
  endfunction : pin_active

  logic [1:0]  mode;
  logic        g3_dir;
  logic        g3_sense;
  logic        wr_ctrl;
  logic        wr_wdog;
  logic        clr_flags;
  logic        cmp_eq;
  logic        match_rise;
  logic        in_capture;
  logic        tick_mode;
  logic [31:0] status_word;

  always_comb begin
    mode       = s_q.ctrl[CT_MODE_LSB +: 2];
    g3_dir     = s_q.ctrl[CT_G3_DIR_BIT];
    g3_sense   = s_q.ctrl[CT_G3_SENSE_BIT];
    wr_ctrl    = reg_wr && (reg_slot == SLOT_CONTROL);
    wr_wdog    = reg_wr && (reg_slot == SLOT_WATCHDOG);
    // the clear comes from the written value, taking effect on the move
    clr_flags  = (wr_ctrl && reg_wdata[CT_MODE_HI_BIT]) || wr_wdog;
    cmp_eq     = (s_q.wdog == free_running_tick_count[15:0]);
    match_rise = cmp_eq && !s_q.prev_match;
    in_capture = (mode == MODE_CAPTURE);
    tick_mode  = (mode == MODE_TICK_IRQ);
    status_word = '0;
    status_word[ST_EVENT_BIT] = s_q.event_flag;
    status_word[ST_MATCH_BIT] = s_q.match_flag;
    status_word[ST_GPIO_LSB +: 3] = gpio_lvl;
    status_word[ST_IRQ_LSB +: 4]  = irq_lvl;
  end

  always_comb begin
    s_d = s_q;
    if (clk_en) begin
      s_d.prev_match = cmp_eq;
      s_d.hit        = reg_rd && ((reg_slot == SLOT_STATUS) || (reg_slot == SLOT_WATCHDOG));
      s_d.rdata      = '0;
      if (reg_rd && reg_slot == SLOT_STATUS) begin
        s_d.rdata = status_word;
      end else if (reg_rd && reg_slot == SLOT_WATCHDOG) begin
        s_d.rdata = {16'h0000, s_q.wdog};
      end
      // reserved bits are stored as written; software keeps them intact
      if (wr_ctrl) begin
        s_d.ctrl = reg_wdata;
      end
      if (wr_wdog) begin
        s_d.wdog = reg_wdata[15:0];
      end
      // event flag and capture of the tick count
      if (in_capture && g3_dir && !s_q.event_flag &&
          pin_active(gpio_lvl[2], g3_sense)) begin
        s_d.event_flag = 1'b1;
        if (!wr_wdog) begin
          s_d.wdog = free_running_tick_count[15:0];
        end
      end
      // match only before an event in capture input mode
      if ((in_capture && !(g3_dir && s_q.event_flag)) || tick_mode) begin
        if (cmp_eq) begin
          s_d.match_flag = 1'b1;
        end
      end
      if (in_capture && !g3_dir && match_rise) begin
        s_d.toggle = ~s_q.toggle;
      end
      if (clr_flags) begin
        s_d.event_flag = 1'b0;
        s_d.match_flag = 1'b0;
      end
      if (wr_ctrl && reg_wdata[CT_MODE_HI_BIT]) begin
        s_d.toggle = 1'b0;
      end
      // output level register per gpio
      s_d.gout[0] = s_q.ctrl[CT_G1_SENSE_BIT];
      s_d.gout[1] = s_q.ctrl[CT_G2_SENSE_BIT];
      s_d.gout[2] = (in_capture) ? (s_q.toggle != g3_sense) : g3_sense;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q.ctrl       <= CT_RESET;
      s_q.wdog       <= WD_RESET;
      s_q.event_flag <= 1'b0;
      s_q.match_flag <= 1'b0;
      s_q.toggle     <= 1'b0;
      s_q.prev_match <= 1'b0;
      s_q.rdata      <= '0;
      s_q.hit        <= 1'b0;
      s_q.gout       <= 3'b000;
    end else begin
      s_q <= s_d;
    end
  end

  logic [3:0] irq_req;
  logic [2:0] gpio_req;
  logic [2:0] gpio_mask;
  logic [2:0] gpio_sense;
  logic [2:0] gpio_dir;

  always_comb begin
    gpio_mask  = {s_q.ctrl[CT_G3_MASK_BIT], s_q.ctrl[CT_G2_MASK_BIT],
                  s_q.ctrl[CT_G1_MASK_BIT]};
    gpio_sense = {g3_sense, s_q.ctrl[CT_G2_SENSE_BIT], s_q.ctrl[CT_G1_SENSE_BIT]};
    gpio_dir   = {g3_dir, s_q.ctrl[CT_G2_DIR_BIT], s_q.ctrl[CT_G1_DIR_BIT]};
    for (int i = 0; i < 4; i++) begin
      // level sensitive: no latching, follows the synchronised pin
      irq_req[i] = !s_q.ctrl[CT_IRQ_OFF_LSB + i] &&
                   pin_active(irq_lvl[i], s_q.ctrl[CT_IRQ_HIGH_LSB + i]);
    end
    for (int j = 0; j < 3; j++) begin
      gpio_req[j] = gpio_dir[j] && !gpio_mask[j] &&
                    pin_active(gpio_lvl[j], gpio_sense[j]);
    end
    // pin 3 capture and tick-irq modes raise through flags
    if (in_capture) begin
      gpio_req[2] = !gpio_mask[2] && (s_q.event_flag || s_q.match_flag);
    end
    if (tick_mode && s_q.match_flag) begin
      gpio_req[2] = 1'b1; // regardless of mask in tick-irq mode
    end
  end

  assign irq_pin_req    = irq_req;
  assign gpio_irq_req   = gpio_req;
  assign gpio_oe        = ~gpio_dir;
  assign gpio_out       = s_q.gout;
  assign reg_rdata      = s_q.rdata;
  assign reg_hit        = s_q.hit;
  assign tick_irq_off   = s_q.ctrl[CT_TICK_OFF_BIT];
  assign tick_irq_prio  = rank_prio(s_q.ctrl[CT_RANK_LSB +: 2]);
  assign dma_lockout    = !s_q.ctrl[CT_DMA_BIT];
  assign extended_overflow_exception_off = s_q.ctrl[CT_EOV_BIT];
  assign watchdog_reset_req = (mode == MODE_WATCHDOG) && cmp_eq;
endmodule : pic_ctrl
`default_nettype wire

//--- rtl/pic_pkg.sv
// package for the pin status and function control block
// assumes a single 40 MHz processor clock domain
package pic_pkg;
  // global register slots
  localparam logic [4:0]  SLOT_WATCHDOG    = 5'h18;
  localparam logic [4:0]  SLOT_STATUS      = 5'h19;
  localparam logic [4:0]  SLOT_CONTROL     = 5'h1a;
  // status fields
  localparam int          ST_EVENT_BIT     = 8;
  localparam int          ST_MATCH_BIT     = 7;
  localparam int          ST_GPIO_LSB      = 4;
  localparam int          ST_IRQ_LSB       = 0;
  // control fields
  localparam int          CT_IRQ_OFF_LSB   = 28;
  localparam int          CT_IRQ_HIGH_LSB  = 24;
  localparam int          CT_TICK_OFF_BIT  = 23;
  localparam int          CT_RANK_LSB      = 20;
  localparam int          CT_DMA_BIT       = 17;
  localparam int          CT_EOV_BIT       = 16;
  localparam int          CT_MODE_LSB      = 12;
  localparam int          CT_MODE_HI_BIT   = 13;
  localparam int          CT_G3_DIR_BIT    = 10;
  localparam int          CT_G3_SENSE_BIT  = 9;
  localparam int          CT_G3_MASK_BIT   = 8;
  localparam int          CT_G2_DIR_BIT    = 6;
  localparam int          CT_G2_SENSE_BIT  = 5;
  localparam int          CT_G2_MASK_BIT   = 4;
  localparam int          CT_G1_DIR_BIT    = 2;
  localparam int          CT_G1_SENSE_BIT  = 1;
  localparam int          CT_G1_MASK_BIT   = 0;
  localparam logic [31:0] CT_RESET         = 32'hffff_ffff;
  localparam logic [15:0] WD_RESET         = 16'h0000;
  // pin 3 modes
  localparam logic [1:0]  MODE_STANDARD    = 2'b11;
  localparam logic [1:0]  MODE_WATCHDOG    = 2'b10;
  localparam logic [1:0]  MODE_CAPTURE     = 2'b01;
  localparam logic [1:0]  MODE_TICK_IRQ    = 2'b00;
  // timer irq priority levels by rank code 0..3
  localparam logic [3:0]  PRIO_RANK0       = 4'hc;
  localparam logic [3:0]  PRIO_RANK1       = 4'ha;
  localparam logic [3:0]  PRIO_RANK2       = 4'h8;
  localparam logic [3:0]  PRIO_RANK3       = 4'h6;
  localparam int          SYNC_STAGES      = 2;
endpackage : pic_pkg

//--- rtl/pic_sync.sv
// two-stage synchroniser bank for pin levels
// assumes inputs asynchronous to clock; clock enable freezes stages
`timescale 1ns/10ps
`default_nettype none
module pic_sync #(
  parameter int WIDTH = 7
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  import pic_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } pic_sync_state_t;

  pic_sync_state_t s_q;
  pic_sync_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (clk_en) begin
      // first stage feeds only the second
      s_d.meta   = async_in;
      s_d.stable = s_q.meta;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_out = s_q.stable;
endmodule : pic_sync
`default_nettype wire

//--- test/pic_ctrl_monitor.sv
// checker on the pic_ctrl register port and control outputs
// assumes one clock domain with rst asynchronous, active high
`timescale 1ns/10ps
`default_nettype none
module pic_ctrl_monitor
  import pic_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        clk_en,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [4:0]  reg_slot,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic        reg_hit,
  input wire logic [2:0]  gpio_oe,
  input wire logic [3:0]  irq_pin_req,
  input wire logic        tick_irq_off,
  input wire logic [3:0]  tick_irq_prio,
  input wire logic        dma_lockout,
  input wire logic        extended_overflow_exception_off
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence ctrl_wr_s;
    clk_en && reg_wr && (reg_slot == SLOT_CONTROL);
  endsequence
  sequence rd_s(s);
    clk_en && reg_rd && (reg_slot == s);
  endsequence
  a_ctrl_no_readback: assert property (rd_s(SLOT_CONTROL) |=> !reg_hit && reg_rdata == '0)
    else $error("control register read returned data");
  a_status_rsvd_zero: assert property (rd_s(SLOT_STATUS) |=> reg_hit && reg_rdata[31:9] == '0)
    else $error("status reserved bits not zero");
  a_wd_upper_zero: assert property (rd_s(SLOT_WATCHDOG) |=> reg_hit && reg_rdata[31:16] == '0)
    else $error("watchdog upper bits not zero");
  a_tick_off_bit: assert property (ctrl_wr_s |=> tick_irq_off == $past(reg_wdata[23]))
    else $error("timer irq disable wrong");
  a_prio_rank: assert property (ctrl_wr_s
    |=> tick_irq_prio == 4'hc - {1'b0, $past(reg_wdata[21:20]), 1'b0})
    else $error("timer priority wrong");
  a_dma_lock: assert property (ctrl_wr_s |=> dma_lockout == !$past(reg_wdata[17]))
    else $error("dma lockout wrong");
  a_eov_gate: assert property (ctrl_wr_s
    |=> extended_overflow_exception_off == $past(reg_wdata[16]))
    else $error("overflow exception gate wrong");
  a_gpio_dir: assert property (ctrl_wr_s
    |=> gpio_oe == ~{$past(reg_wdata[10]), $past(reg_wdata[6]), $past(reg_wdata[2])})
    else $error("gpio direction wrong");
  a_irq_masked: assert property (ctrl_wr_s ##0 reg_wdata[31:28] == 4'hf |=> irq_pin_req == '0)
    else $error("masked pin raised request");
  a_reset_ones: assert property ($fell(rst) |-> tick_irq_off && extended_overflow_exception_off
    && !dma_lockout && gpio_oe == '0 && irq_pin_req == '0 && tick_irq_prio == 4'h6)
    else $error("control outputs wrong after reset");
endmodule : pic_ctrl_monitor
`default_nettype wire

//--- test/pic_pin_model.sv
// external pin sources: four interrupt pins and three gpio pins
// assumes levels change shortly after a clock edge, asynchronous to the core
`timescale 1ns/10ps
`default_nettype none
module pic_pin_model (
  input  wire logic       clock,
  input  wire logic       load,
  input  wire logic [6:0] levels,
  input  wire logic [2:0] gpio_out,
  input  wire logic [2:0] gpio_oe,
  output logic      [3:0] irq_pin_in,
  output logic      [2:0] gpio_in
);
  logic [2:0] gpio_drv;
  initial {gpio_drv, irq_pin_in} = 7'h00;
  always @(posedge clock) if (load) #3 {gpio_drv, irq_pin_in} <= levels;
  // pin level resolved from whoever drives it
  assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & gpio_drv);
endmodule : pic_pin_model
`default_nettype wire

//--- test/pic_ctrl_tb.sv
// self-checking bench for pic_ctrl: random control words and pin levels
// assumes clk_en held high; tick count made here, one step per clock
`timescale 1ns/10ps
`default_nettype none
module pic_ctrl_tb;
  import pic_pkg::*;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        clk_en = 1'b1;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        load = 1'b0;
  logic        saw_wreq = 1'b0;
  logic        h;
  logic [4:0]  reg_slot = 5'h00;
  logic [6:0]  levels = 7'h00;
  logic [15:0] tick = 16'h0000;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic [31:0] reg_rdata, c, w, d;
  logic [3:0]  irq_pin_in, irq_pin_req, tick_irq_prio;
  logic [2:0]  gpio_in, gpio_out, gpio_oe, gpio_irq_req;
  logic        reg_hit, tick_irq_off, dma_lockout, eov_off, wd_req;
  int          err_count = 0;
  int          tests_run = 0;
  always #12.5 clock = ~clock;
  always @(posedge clock) #1 tick <= tick + 16'h0001;
  always @(posedge clock) if (wd_req === 1'b1) saw_wreq <= 1'b1;
  pic_ctrl pic_ctrl_inst (.clock(clock), .rst(rst), .clk_en(clk_en), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_slot(reg_slot), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_hit(reg_hit), .free_running_tick_count(tick), .irq_pin_in(irq_pin_in),
    .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .irq_pin_req(irq_pin_req),
    .gpio_irq_req(gpio_irq_req), .tick_irq_off(tick_irq_off), .tick_irq_prio(tick_irq_prio),
    .dma_lockout(dma_lockout), .extended_overflow_exception_off(eov_off),
    .watchdog_reset_req(wd_req));
  pic_pin_model pic_pin_model_inst (.clock(clock), .load(load), .levels(levels),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .irq_pin_in(irq_pin_in), .gpio_in(gpio_in));
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step
  task automatic wr(input logic [4:0] s, input logic [31:0] v);
    reg_slot = s;
    reg_wdata = v;
    reg_wr = 1'b1;
    step(1);
    reg_wr = 1'b0;
    // one idle edge so a following call never re-raises the strobe at once
    step(1);
  endtask : wr
  task automatic rd(input logic [4:0] s, output logic [31:0] v, output logic hit);
    reg_slot = s;
    reg_rd = 1'b1;
    step(1);
    v = reg_rdata;
    hit = reg_hit;
    reg_rd = 1'b0;
    step(1);
  endtask : rd
  task automatic pins(input logic [6:0] v);
    levels = v;
    load = 1'b1;
    step(1);
    load = 1'b0;
  endtask : pins
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  function automatic logic [3:0] prio_of(input logic [1:0] r);
    return 4'hc - {1'b0, r, 1'b0};
  endfunction : prio_of
  // true pin level: input pins follow the source, output pins show their sense bit
  function automatic logic [2:0] gpio_lvl_of(input logic [31:0] cw, input logic [6:0] lv);
    logic [2:0] dir;
    dir = {cw[10], cw[6], cw[2]};
    return (dir & lv[6:4]) | (~dir & {cw[9], cw[5], cw[1]});
  endfunction : gpio_lvl_of
  function automatic logic [2:0] gpio_req_of(input logic [31:0] cw, input logic [6:0] lv);
    logic [2:0] dir;
    dir = {cw[10], cw[6], cw[2]};
    return dir & ~{cw[8], cw[4], cw[0]} & ~(lv[6:4] ^ {cw[9], cw[5], cw[1]});
  endfunction : gpio_req_of
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict
  initial begin
    #(25 * 4000);
    err_count++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'hcf25_ab51));
    step(12);
    rst = 1'b0;
    check({tick_irq_off, tick_irq_prio, dma_lockout, eov_off, gpio_oe, irq_pin_req}, 32'h0000_2c80);
    rd(SLOT_CONTROL, d, h);
    check({d[30:0], h}, 32'h0000_0000);
    rd(5'h03, d, h);
    check({d[30:0], h}, 32'h0000_0000);
    $display("test refusal done");
    for (int i = 0; i < 24; i++) begin
      // reserved bits stay one, standard mode keeps both flags clear
      c = $urandom | 32'h004c_f888;
      // an output pin with its mask bit low is a reserved setting, keep it off
      c = c | {23'h0, ~c[10], 3'h0, ~c[6], 3'h0, ~c[2]};
      w = $urandom;
      pins(7'($urandom));
      wr(SLOT_CONTROL, c);
      wr(SLOT_WATCHDOG, w);
      step(4);
      rd(SLOT_STATUS, d, h);
      check(d, {23'h0, 2'b00, gpio_lvl_of(c, levels), levels[3:0]});
      check({31'h0, h}, 32'h0000_0001);
      rd(SLOT_WATCHDOG, d, h);
      check(d, {16'h0000, w[15:0]});
      check({28'h0, irq_pin_req}, {28'h0, ~c[31:28] & ~(levels[3:0] ^ c[27:24])});
      check({tick_irq_off, tick_irq_prio, dma_lockout, eov_off}, {c[23], prio_of(c[21:20]), !c[17], c[16]});
      check({29'h0, gpio_oe}, {29'h0, ~c[10], ~c[6], ~c[2]});
      check({29'h0, gpio_irq_req}, {29'h0, gpio_req_of(c, levels)});
    end
    $display("test random control done");
    for (int m = 0; m < 2; m++) begin
      saw_wreq = 1'b0;
      wr(SLOT_WATCHDOG, {16'h0000, tick + 16'h001e});
      wr(SLOT_CONTROL, (m == 0) ? 32'hffff_cfff : 32'hffff_efff);
      step(45);
      rd(SLOT_STATUS, d, h);
      check({30'h0, d[8:7]}, (m == 0) ? 32'h1 : 32'h0);
      check({31'h0, saw_wreq}, 32'(m));
    end
    wr(SLOT_WATCHDOG, {16'h0000, tick + 16'h0014});
    wr(SLOT_CONTROL, 32'hffff_cfff);
    step(40);
    rd(SLOT_STATUS, d, h);
    check({30'h0, d[8:7]}, 32'h0000_0001);
    wr(SLOT_CONTROL, 32'hffff_ffff);
    rd(SLOT_STATUS, d, h);
    check({30'h0, d[8:7]}, 32'h0);
    pins(7'h40);
    wr(SLOT_CONTROL, 32'hffff_dfff);
    step(6);
    rd(SLOT_STATUS, d, h);
    check({30'h0, d[8:7]}, 32'h2);
    pins(7'h00);
    step(4);
    wr(SLOT_WATCHDOG, 32'h0000_0000);
    rd(SLOT_STATUS, d, h);
    check({30'h0, d[8:7]}, 32'h0);
    // capture mode with pin 3 as output: the match toggles the output level
    wr(SLOT_WATCHDOG, {16'h0000, tick + 16'h0014});
    wr(SLOT_CONTROL, 32'hffff_dbff);
    step(4);
    check({31'h0, gpio_out[2]}, 32'h0000_0001);
    step(30);
    rd(SLOT_STATUS, d, h);
    check({30'h0, d[8:7]}, 32'h0000_0001);
    check({31'h0, gpio_out[2]}, 32'h0);
    $display("test pin 3 modes done");
    give_verdict();
  end
endmodule : pic_ctrl_tb
bind pic_ctrl pic_ctrl_monitor pic_ctrl_monitor_inst (.clock(clock), .rst(rst),
  .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_slot(reg_slot),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit), .gpio_oe(gpio_oe),
  .irq_pin_req(irq_pin_req), .tick_irq_off(tick_irq_off), .tick_irq_prio(tick_irq_prio),
  .dma_lockout(dma_lockout),
  .extended_overflow_exception_off(extended_overflow_exception_off));
`default_nettype wire
